/* File: lmha_regs.svh */
// Constants of the local memory host access controller
`ifndef LMHA_REGS_SVH
`define LMHA_REGS_SVH
`define LMHA_CLK_MHZ 250
`define LMHA_QUARTER_NS 8
`define LMHA_QUARTER_CYC ((`LMHA_QUARTER_NS * `LMHA_CLK_MHZ + 999) / 1000)
`define LMHA_CODE_COPROC 4'h0
`define LMHA_CODE_EMU 4'h1
`define LMHA_CODE_HOST 4'h2
`define LMHA_CODE_REFRESH 4'h3
`define LMHA_CODE_XFER_VIDEO 4'h4
`define LMHA_CODE_XFER_CPU 4'h5
`define LMHA_CODE_WMASK 4'h6
`define LMHA_CODE_COLOR 4'h7
`define LMHA_CODE_DATA 4'h8
`define LMHA_CODE_CACHE 4'h9
`define LMHA_CODE_IFETCH 4'ha
`define LMHA_CODE_VECTOR 4'hb
`define LMHA_CODE_LOCKED 4'hc
`define LMHA_CODE_PIXEL 4'hd
`define LMHA_CODE_BLKW 4'he
`define LMHA_CODE_RSVD 4'hf
`define LMHA_PINS_IDLE 10'h3fe
`define LMHA_PINS_RESET 10'h3ff
`endif

/* File: lmha_pkg.sv */
// Types of the local memory host access controller
`default_nettype none
package lmha_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ADDR = 2'b01,
		ST_DATA = 2'b11,
		ST_OFF = 2'b10
	} lmha_state_type;
	typedef enum logic [1:0] {
		SRC_CPU = 2'b00,
		SRC_HOST = 2'b01,
		SRC_PF = 2'b10
	} lmha_src_type;
	typedef struct packed {
		logic [3:0] code;
		logic [26:0] addr;
		logic [3:0] be;
		logic write;
		logic rmw;
		logic masked;
	} lmha_req_type;
	typedef struct packed {
		logic lad_oe_n;
		logic address_latch_strobe_n;
		logic ras_n;
		logic [3:0] cas_n;
		logic we_n;
		logic trqe_n;
		logic sf;
	} lmha_pins_type;
endpackage
`default_nettype wire

/* File: lmha_ctrl.sv */
// Local memory bus controller: cycle codes, dynamic sizing, bus release, host port
`include "lmha_regs.svh"
`default_nettype none
module lmha_ctrl (
	input wire logic CLK_IN,
	input wire logic RST_IN,
	input wire logic [31:0] LOCAL_ADDR_DATA_BUS_IN,
	output logic [31:0] LOCAL_ADDR_DATA_BUS_OUT,
	output logic LOCAL_ADDR_DATA_BUS_OE_N_OUT,
	output logic ADDRESS_LATCH_STROBE_N_OUT,
	output logic RAS_N_OUT,
	output logic [3:0] CAS_N_OUT,
	output logic WE_N_OUT,
	output logic TRANSFER_OUTPUT_ENABLE_N_OUT,
	output logic SPECIAL_FUNCTION_PIN_OUT,
	input wire logic HALF_WIDTH_ACK_N_IN,
	input wire logic PAGE_MODE_ACK_N_IN,
	input wire logic BUS_FAULT_IN,
	input wire logic BUS_GRANT_N_IN,
	output logic PRIORITY_REQUEST_A_N_OUT,
	output logic PRIORITY_REQUEST_B_N_OUT,
	input wire logic [26:0] HOST_LONGWORD_ADDR_IN,
	input wire logic [3:0] HOST_BYTE_SELECTS_N_IN,
	input wire logic HOST_SELECT_N_IN,
	input wire logic HOST_READ_REQ_N_IN,
	input wire logic HOST_WRITE_REQ_N_IN,
	input wire logic HOST_INCREMENT_EN_IN,
	input wire logic HOST_PREFETCH_WRITE_EN_IN,
	output logic HOST_READY_OUT,
	output logic HOST_DATA_STROBE_N_OUT,
	output logic HOST_OUTPUT_ENABLE_N_OUT,
	input wire logic CPU_REQ_VALID_IN,
	input wire lmha_pkg::lmha_req_type CPU_REQ_IN,
	input wire logic [31:0] CPU_WDATA_IN,
	output logic CPU_ACCEPT_OUT,
	output logic CPU_DONE_OUT,
	output logic [31:0] CPU_RDATA_OUT
);
	import lmha_pkg::*;

	logic [1:0] qcnt_r, qcnt_nxt;
	logic qen;
	lmha_state_type st_r, st_nxt;
	lmha_src_type src_r, src_nxt;
	lmha_pins_type pins_r, pins_nxt;
	lmha_req_type req_r, req_nxt;
	logic [1:0] q_r, q_nxt;
	logic [31:0] lad_r, lad_nxt, wdata_r, wdata_nxt, rdata_r, rdata_nxt;
	logic word_r, word_nxt, half16_r, half16_nxt, upper_r, upper_nxt;
	logic page_r, page_nxt, wph_r, wph_nxt, fault_r, fault_nxt, pend_r, pend_nxt;
	logic prio_a_r, prio_a_nxt, prio_b_r, prio_b_nxt;
	logic acc_r, acc_nxt, done_r, done_nxt;
	logic eff_wr, swap, special, xfer, pf_hit, host_cand, pf_cand;
	logic take_host, take_pf, eng_fin, rd_cap, hwr_on, bnd, complete, goto_next;
	logic [3:0] mask, cas_m;
	logic [31:0] wd_sw;
	logic [26:0] haddr_r, haddr_nxt, pf_addr_r, pf_addr_nxt;
	logic [3:0] hbs_r, hbs_nxt;
	logic hsel_d_r, hsel_d_nxt, hwq_d_r, hwq_d_nxt, hsel_fall;
	logic served_r, served_nxt, hrd_pend_r, hrd_pend_nxt, hwr_pend_r, hwr_pend_nxt;
	logic pf_valid_r, pf_valid_nxt, pf_pend_r, pf_pend_nxt;
	logic ready_r, ready_nxt, hds_r, hds_nxt, hoe_r, hoe_nxt;

	function automatic logic [31:0] addr_word(input logic [26:0] a, input logic w,
		input logic [3:0] c);
		addr_word = {a, w, c};
	endfunction

	// Quarter-cycle enable
	always_comb begin
		qen = (qcnt_r == 2'(`LMHA_QUARTER_CYC - 1));
		qcnt_nxt = qen ? 2'h0 : qcnt_r + 2'h1;
	end

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			qcnt_r <= 2'h0;
		end else begin
			qcnt_r <= qcnt_nxt;
		end
	end

	// Bus engine
	always_comb begin
		st_nxt = st_r;
		src_nxt = src_r;
		pins_nxt = pins_r;
		req_nxt = req_r;
		q_nxt = q_r;
		lad_nxt = lad_r;
		wdata_nxt = wdata_r;
		rdata_nxt = rdata_r;
		word_nxt = word_r;
		half16_nxt = half16_r;
		upper_nxt = upper_r;
		page_nxt = page_r;
		wph_nxt = wph_r;
		fault_nxt = fault_r;
		pend_nxt = pend_r;
		acc_nxt = 1'b0;
		done_nxt = 1'b0;
		take_host = 1'b0;
		take_pf = 1'b0;
		eng_fin = 1'b0;
		rd_cap = 1'b0;
		hwr_on = 1'b0;
		bnd = 1'b0;
		complete = 1'b0;
		goto_next = 1'b0;
		pf_hit = pf_valid_r & HOST_INCREMENT_EN_IN & (pf_addr_r == haddr_r);
		host_cand = hwr_pend_r | (hrd_pend_r & ~pf_hit);
		// Prefetch waits for the host to deselect so the latched read data survives
		pf_cand = pf_pend_r & HOST_SELECT_N_IN;
		eff_wr = req_r.write & ~(req_r.rmw & ~wph_r);
		mask = eff_wr ? req_r.be : 4'hf;
		swap = word_r & half16_r;
		cas_m = swap ? {mask[1:0], mask[3:2]} : mask;
		wd_sw = swap ? {wdata_r[15:0], wdata_r[31:16]} : wdata_r;
		special = (req_r.code == `LMHA_CODE_WMASK) | (req_r.code == `LMHA_CODE_COLOR) |
			(req_r.code == `LMHA_CODE_BLKW);
		xfer = (req_r.code == `LMHA_CODE_XFER_VIDEO) | (req_r.code == `LMHA_CODE_XFER_CPU);
		prio_a_nxt = ~(CPU_REQ_VALID_IN | host_cand | pf_cand | pend_r);
		prio_b_nxt = ~host_cand;
		if (st_r == ST_DATA) begin
			fault_nxt = fault_r | BUS_FAULT_IN;
		end
		if (qen) begin
			q_nxt = q_r + 2'h1;
			unique case (st_r)
			ST_IDLE: begin
				q_nxt = 2'h0;
				if (!BUS_GRANT_N_IN && (host_cand || pf_cand || CPU_REQ_VALID_IN)) begin
					word_nxt = 1'b0;
					wph_nxt = 1'b0;
					half16_nxt = 1'b0;
					upper_nxt = 1'b0;
					page_nxt = 1'b0;
					fault_nxt = 1'b0;
					pend_nxt = 1'b1;
					st_nxt = ST_ADDR;
					if (host_cand) begin
						take_host = 1'b1;
						src_nxt = SRC_HOST;
						req_nxt = '{code: `LMHA_CODE_HOST, addr: haddr_r, be: hbs_r,
							write: hwr_pend_r, rmw: 1'b0, masked: 1'b0};
					end else if (pf_cand) begin
						take_pf = 1'b1;
						src_nxt = SRC_PF;
						req_nxt = '{code: `LMHA_CODE_HOST, addr: pf_addr_r, be: 4'hf,
							write: 1'b0, rmw: 1'b0, masked: 1'b0};
					end else begin
						acc_nxt = 1'b1;
						src_nxt = SRC_CPU;
						req_nxt = CPU_REQ_IN;
						wdata_nxt = CPU_WDATA_IN;
						if (CPU_REQ_IN.code == `LMHA_CODE_RSVD) begin
							req_nxt.code = `LMHA_CODE_DATA;
						end
					end
					lad_nxt = addr_word(req_nxt.addr, 1'b0, req_nxt.code);
					pins_nxt.lad_oe_n = 1'b0;
				end
			end
			ST_ADDR: begin
				unique case (q_r)
				2'h0: begin
					pins_nxt.address_latch_strobe_n = 1'b0;
					if (req_r.code == `LMHA_CODE_REFRESH) begin
						pins_nxt.cas_n = 4'h0;
					end
				end
				2'h1: begin
					pins_nxt.ras_n = 1'b0;
					pins_nxt.sf = special;
					pins_nxt.we_n = ~(req_r.masked | (req_r.code == `LMHA_CODE_WMASK) |
						(req_r.code == `LMHA_CODE_COLOR));
					pins_nxt.trqe_n = ~xfer;
				end
				2'h2: begin
					pins_nxt.address_latch_strobe_n = 1'b1;
					pins_nxt.sf = 1'b0;
					pins_nxt.we_n = 1'b1;
					pins_nxt.trqe_n = 1'b1;
				end
				2'h3: begin
					if (req_r.code == `LMHA_CODE_REFRESH) begin
						bnd = 1'b1;
						complete = 1'b1;
					end else begin
						st_nxt = ST_DATA;
						pins_nxt.lad_oe_n = 1'b1;
					end
				end
				endcase
			end
			ST_DATA: begin
				unique case (q_r)
				2'h0: begin
					if (!word_r) begin
						half16_nxt = ~HALF_WIDTH_ACK_N_IN;
						page_nxt = ~PAGE_MODE_ACK_N_IN;
					end else begin
						upper_nxt = HALF_WIDTH_ACK_N_IN;
					end
					if (eff_wr) begin
						pins_nxt.we_n = 1'b0;
						if (src_r == SRC_CPU) begin
							lad_nxt = wd_sw;
							pins_nxt.lad_oe_n = 1'b0;
						end else begin
							hwr_on = 1'b1;
						end
					end
				end
				2'h1: begin
					pins_nxt.cas_n = ~cas_m;
				end
				2'h2: begin
					if (!eff_wr) begin
						rd_cap = 1'b1;
						if (!swap) begin
							rdata_nxt = LOCAL_ADDR_DATA_BUS_IN;
						end else if (upper_r) begin
							rdata_nxt[15:0] = LOCAL_ADDR_DATA_BUS_IN[31:16];
						end else begin
							rdata_nxt[31:16] = LOCAL_ADDR_DATA_BUS_IN[15:0];
						end
					end
				end
				2'h3: begin
					bnd = 1'b1;
					if (fault_nxt) begin
						word_nxt = 1'b0;
						wph_nxt = 1'b0;
						fault_nxt = 1'b0;
					end else if (!word_r && half16_r) begin
						word_nxt = 1'b1;
						goto_next = 1'b1;
					end else if (req_r.rmw && !wph_r) begin
						wph_nxt = 1'b1;
						word_nxt = 1'b0;
						goto_next = 1'b1;
					end else begin
						complete = 1'b1;
					end
				end
				endcase
			end
			ST_OFF: begin
				q_nxt = 2'h0;
				if (!BUS_GRANT_N_IN) begin
					if (pend_r) begin
						st_nxt = ST_ADDR;
						half16_nxt = 1'b0;
						fault_nxt = 1'b0;
						pins_nxt.lad_oe_n = 1'b0;
						lad_nxt = addr_word(req_r.addr, 1'b0, req_r.code);
					end else begin
						st_nxt = ST_IDLE;
					end
				end
			end
			endcase
			if (bnd) begin
				pins_nxt.cas_n = 4'hf;
				pins_nxt.we_n = 1'b1;
				pins_nxt.lad_oe_n = 1'b1;
				if (complete) begin
					eng_fin = 1'b1;
					pend_nxt = 1'b0;
					pins_nxt.ras_n = 1'b1;
					done_nxt = (src_r == SRC_CPU);
					st_nxt = ST_IDLE;
				end else if (goto_next && page_r) begin
					st_nxt = ST_DATA;
				end else begin
					st_nxt = ST_ADDR;
					pins_nxt.ras_n = 1'b1;
					pins_nxt.lad_oe_n = 1'b0;
					lad_nxt = addr_word(req_r.addr, word_nxt, req_r.code);
				end
				if (BUS_GRANT_N_IN) begin
					// Unfinished work restarts from its address cycle on regrant
					st_nxt = ST_OFF;
					pins_nxt = `LMHA_PINS_IDLE;
					word_nxt = 1'b0;
					wph_nxt = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			st_r <= ST_IDLE;
			src_r <= SRC_CPU;
			pins_r <= `LMHA_PINS_RESET;
			req_r <= '0;
			q_r <= 2'h0;
			lad_r <= 32'h0000_0000;
			wdata_r <= 32'h0000_0000;
			rdata_r <= 32'h0000_0000;
			word_r <= 1'b0;
			half16_r <= 1'b0;
			upper_r <= 1'b0;
			page_r <= 1'b0;
			wph_r <= 1'b0;
			fault_r <= 1'b0;
			pend_r <= 1'b0;
			prio_a_r <= 1'b1;
			prio_b_r <= 1'b1;
			acc_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			src_r <= src_nxt;
			pins_r <= pins_nxt;
			req_r <= req_nxt;
			q_r <= q_nxt;
			lad_r <= lad_nxt;
			wdata_r <= wdata_nxt;
			rdata_r <= rdata_nxt;
			word_r <= word_nxt;
			half16_r <= half16_nxt;
			upper_r <= upper_nxt;
			page_r <= page_nxt;
			wph_r <= wph_nxt;
			fault_r <= fault_nxt;
			pend_r <= pend_nxt;
			prio_a_r <= prio_a_nxt;
			prio_b_r <= prio_b_nxt;
			acc_r <= acc_nxt;
			done_r <= done_nxt;
		end
	end

	// Host port
	always_comb begin
		hsel_d_nxt = HOST_SELECT_N_IN;
		hwq_d_nxt = HOST_WRITE_REQ_N_IN;
		haddr_nxt = haddr_r;
		hbs_nxt = hbs_r;
		served_nxt = served_r;
		hrd_pend_nxt = hrd_pend_r;
		hwr_pend_nxt = hwr_pend_r;
		pf_valid_nxt = pf_valid_r;
		pf_pend_nxt = pf_pend_r;
		pf_addr_nxt = pf_addr_r;
		ready_nxt = ready_r;
		hds_nxt = hds_r;
		hoe_nxt = hoe_r;
		hsel_fall = hsel_d_r & ~HOST_SELECT_N_IN;
		if (hsel_fall) begin
			haddr_nxt = HOST_LONGWORD_ADDR_IN;
			hbs_nxt = ~HOST_BYTE_SELECTS_N_IN;
		end
		if (!HOST_SELECT_N_IN && !hsel_fall && !served_r) begin
			// Both requests low at once is ignored
			if (!HOST_READ_REQ_N_IN && HOST_WRITE_REQ_N_IN) begin
				served_nxt = 1'b1;
				if (pf_hit) begin
					ready_nxt = 1'b1;
				end else begin
					hrd_pend_nxt = 1'b1;
				end
			end else if (!hwq_d_r && HOST_WRITE_REQ_N_IN && HOST_READ_REQ_N_IN) begin
				served_nxt = 1'b1;
				hwr_pend_nxt = 1'b1;
				if (pf_addr_r == haddr_r) begin
					pf_valid_nxt = 1'b0;
				end
			end
		end
		if (take_host) begin
			hrd_pend_nxt = 1'b0;
			hwr_pend_nxt = 1'b0;
		end
		if (take_pf) begin
			pf_pend_nxt = 1'b0;
		end
		if (rd_cap && src_r != SRC_CPU) begin
			hds_nxt = 1'b0;
		end
		if (hwr_on) begin
			hoe_nxt = 1'b0;
		end
		if (eng_fin && src_r == SRC_HOST) begin
			ready_nxt = 1'b1;
			if (HOST_INCREMENT_EN_IN && (req_r.write == HOST_PREFETCH_WRITE_EN_IN)) begin
				pf_pend_nxt = 1'b1;
				pf_valid_nxt = 1'b0;
				pf_addr_nxt = haddr_r + 27'h1;
			end
		end
		if (eng_fin && src_r == SRC_PF) begin
			pf_valid_nxt = 1'b1;
			hds_nxt = 1'b1;
		end
		if (ready_r) begin
			hds_nxt = 1'b1;
			hoe_nxt = 1'b1;
		end
		if (HOST_SELECT_N_IN) begin
			ready_nxt = 1'b0;
			served_nxt = 1'b0;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			hsel_d_r <= 1'b1;
			hwq_d_r <= 1'b1;
			haddr_r <= 27'h000_0000;
			hbs_r <= 4'h0;
			served_r <= 1'b0;
			hrd_pend_r <= 1'b0;
			hwr_pend_r <= 1'b0;
			pf_valid_r <= 1'b0;
			pf_pend_r <= 1'b0;
			pf_addr_r <= 27'h000_0000;
			ready_r <= 1'b0;
			hds_r <= 1'b1;
			hoe_r <= 1'b1;
		end else begin
			hsel_d_r <= hsel_d_nxt;
			hwq_d_r <= hwq_d_nxt;
			haddr_r <= haddr_nxt;
			hbs_r <= hbs_nxt;
			served_r <= served_nxt;
			hrd_pend_r <= hrd_pend_nxt;
			hwr_pend_r <= hwr_pend_nxt;
			pf_valid_r <= pf_valid_nxt;
			pf_pend_r <= pf_pend_nxt;
			pf_addr_r <= pf_addr_nxt;
			ready_r <= ready_nxt;
			hds_r <= hds_nxt;
			hoe_r <= hoe_nxt;
		end
	end

	assign LOCAL_ADDR_DATA_BUS_OUT = lad_r;
	assign LOCAL_ADDR_DATA_BUS_OE_N_OUT = pins_r.lad_oe_n;
	assign ADDRESS_LATCH_STROBE_N_OUT = pins_r.address_latch_strobe_n;
	assign RAS_N_OUT = pins_r.ras_n;
	assign CAS_N_OUT = pins_r.cas_n;
	assign WE_N_OUT = pins_r.we_n;
	assign TRANSFER_OUTPUT_ENABLE_N_OUT = pins_r.trqe_n;
	assign SPECIAL_FUNCTION_PIN_OUT = pins_r.sf;
	assign PRIORITY_REQUEST_A_N_OUT = prio_a_r;
	assign PRIORITY_REQUEST_B_N_OUT = prio_b_r;
	assign HOST_READY_OUT = ready_r;
	assign HOST_DATA_STROBE_N_OUT = hds_r;
	assign HOST_OUTPUT_ENABLE_N_OUT = hoe_r;
	assign CPU_ACCEPT_OUT = acc_r;
	assign CPU_DONE_OUT = done_r;
	assign CPU_RDATA_OUT = rdata_r;
endmodule
`default_nettype wire

/* File: lmha_ctrl_monitor.sv */
// Checker of the local bus and host port pins
`default_nettype none
module lmha_ctrl_monitor (
	input wire logic CLK_IN,
	input wire logic RST_IN,
	input wire logic [31:0] LOCAL_ADDR_DATA_BUS_OUT,
	input wire logic LOCAL_ADDR_DATA_BUS_OE_N_OUT,
	input wire logic ADDRESS_LATCH_STROBE_N_OUT,
	input wire logic RAS_N_OUT,
	input wire logic [3:0] CAS_N_OUT,
	input wire logic BUS_GRANT_N_IN,
	input wire logic [3:0] HOST_BYTE_SELECTS_N_IN,
	input wire logic HOST_SELECT_N_IN,
	input wire logic HOST_READY_OUT,
	input wire logic HOST_DATA_STROBE_N_OUT,
	input wire logic HOST_OUTPUT_ENABLE_N_OUT
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (RST_IN);
	logic [5:0] gnt_cnt_r, gnt_cnt_nxt;
	logic [3:0] sel_n_r, sel_n_nxt;
	logic hsel_d_r;
	// Grant-high run length saturates so a long release never wraps
	always_comb begin
		gnt_cnt_nxt = 6'h00;
		if (BUS_GRANT_N_IN) begin
			gnt_cnt_nxt = gnt_cnt_r + ((gnt_cnt_r != 6'h3f) ? 6'h01 : 6'h00);
		end
		sel_n_nxt = (hsel_d_r && !HOST_SELECT_N_IN) ? HOST_BYTE_SELECTS_N_IN : sel_n_r;
	end
	always_ff @(posedge CLK_IN) begin
		gnt_cnt_r <= RST_IN ? 6'h00 : gnt_cnt_nxt;
		sel_n_r <= RST_IN ? 4'hf : sel_n_nxt;
		hsel_d_r <= RST_IN ? 1'b1 : HOST_SELECT_N_IN;
	end
	AST_CODE_AT_LATCH: assert property ($fell(ADDRESS_LATCH_STROBE_N_OUT) |->
		!LOCAL_ADDR_DATA_BUS_OE_N_OUT && LOCAL_ADDR_DATA_BUS_OUT[3:0] != 4'hf)
		else $error("cycle code not driven or reserved at latch fall");
	AST_LATCH_PULSE: assert property ($fell(ADDRESS_LATCH_STROBE_N_OUT) |->
		(!ADDRESS_LATCH_STROBE_N_OUT)[*4] ##1 ADDRESS_LATCH_STROBE_N_OUT)
		else $error("address latch strobe width wrong");
	AST_RELEASE: assert property (gnt_cnt_r >= 6'h28 |->
		RAS_N_OUT && &CAS_N_OUT && LOCAL_ADDR_DATA_BUS_OE_N_OUT)
		else $error("bus still held after grant removed");
	AST_HWR_BYTES: assert property (!HOST_OUTPUT_ENABLE_N_OUT && CAS_N_OUT != 4'hf |->
		(~CAS_N_OUT & sel_n_r) == 4'h0 || (~CAS_N_OUT & {sel_n_r[1:0], sel_n_r[3:2]}) == 4'h0)
		else $error("host write strobes an unselected byte");
	AST_HRD_FULL: assert property (!HOST_DATA_STROBE_N_OUT && CAS_N_OUT != 4'hf |->
		CAS_N_OUT == 4'h0)
		else $error("host read not full width");
	AST_RDY_HOLD: assert property (HOST_READY_OUT && !HOST_SELECT_N_IN |=> HOST_READY_OUT)
		else $error("host ready dropped while selected");
	// A background prefetch strobes the transceivers with the host away, so no ready then
	AST_HDS_AFTER_RDY: assert property ($rose(HOST_DATA_STROBE_N_OUT) && !$past(RST_IN) &&
		!$past(HOST_SELECT_N_IN) |-> $past(HOST_READY_OUT))
		else $error("data strobe rose before ready");
	AST_HOE_AFTER_RDY: assert property ($rose(HOST_OUTPUT_ENABLE_N_OUT) && !$past(RST_IN) |->
		$past(HOST_READY_OUT) && HOST_READY_OUT)
		else $error("output enable rose without ready");
	COV_HOST_READY: cover property ($rose(HOST_READY_OUT));
	COV_RELEASE: cover property (gnt_cnt_r == 6'h28);
	COV_ODD_WORD: cover property ($fell(ADDRESS_LATCH_STROBE_N_OUT) && LOCAL_ADDR_DATA_BUS_OUT[4]);
endmodule
bind lmha_ctrl lmha_ctrl_monitor u_mon (.CLK_IN, .RST_IN, .LOCAL_ADDR_DATA_BUS_OUT,
	.LOCAL_ADDR_DATA_BUS_OE_N_OUT, .ADDRESS_LATCH_STROBE_N_OUT, .RAS_N_OUT, .CAS_N_OUT,
	.BUS_GRANT_N_IN, .HOST_BYTE_SELECTS_N_IN, .HOST_SELECT_N_IN, .HOST_READY_OUT,
	.HOST_DATA_STROBE_N_OUT, .HOST_OUTPUT_ENABLE_N_OUT);
`default_nettype wire

/* File: lmha_mem_model.sv */
// Memory and host transceiver model on the local bus
`default_nettype none
module lmha_mem_model (
	input wire logic clk_in,
	input wire logic [31:0] lad_out_in,
	input wire logic lad_oe_n_in,
	input wire logic address_latch_strobe_n_in,
	input wire logic [3:0] cas_n_in,
	input wire logic we_n_in,
	input wire logic hoe_n_in,
	input wire logic [31:0] host_wdata_in,
	input wire logic half_in,
	input wire logic upper_in,
	input wire logic page_in,
	output logic [31:0] lad_in_out,
	output logic half_ack_n_out,
	output logic page_ack_n_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] mem [16];
	logic [31:0] noise_r = 32'h5aa5_c33c;
	logic [3:0] addr_r = 4'h0;
	logic [3:0] cas_d_r = 4'hf;
	logic [3:0] lanes;
	logic word_r = 1'b0;
	logic sw;
	initial for (int i = 0; i < 16; i++) mem[i] = 32'h0000_0000;
	assign lanes = !half_in ? 4'hf : upper_in ? 4'hc : 4'h3;
	assign sw = half_in && word_r;
	assign half_ack_n_out = !(half_in && (!word_r || !upper_in));
	assign page_ack_n_out = !page_in;
	// Lanes nobody drives toggle, so a stale value can never pass for data
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			lad_in_out[i*8+:8] = !lad_oe_n_in ? lad_out_in[i*8+:8]
				: !hoe_n_in ? host_wdata_in[i*8+:8]
				: (lanes[i] && !cas_n_in[i] && we_n_in) ? mem[addr_r][(i ^ {sw, 1'b0})*8+:8]
				: noise_r[i*8+:8];
		end
	end
	always @(posedge clk_in) begin
		noise_r <= ~noise_r;
		cas_d_r <= cas_n_in;
		if (!address_latch_strobe_n_in) begin
			{addr_r, word_r} <= lad_out_in[8:4];
		end else if (half_in && &cas_n_in && !(&cas_d_r)) begin
			word_r <= !word_r;
		end
		for (int i = 0; i < 4; i++) begin
			if (!we_n_in && lanes[i] && !cas_n_in[i]) begin
				mem[addr_r][(i ^ {sw, 1'b0})*8+:8] <= lad_in_out[i*8+:8];
			end
		end
	end
endmodule
`default_nettype wire

/* File: lmha_ctrl_tb_top.sv */
// Self-checking bench of the local memory host access controller
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
	$display("unexpected %0t got %0h want %0h", $time, g, e); end end
module lmha_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import lmha_pkg::*;
	logic clk = 0, rst = 1, fault = 0, gnt_n = 0, hsel_n = 1, hrd_n = 1, hwr_n = 1;
	logic inc = 0, pfw = 0, half = 0, upper = 0, page = 0, valid = 0;
	logic oe_n, address_latch_strobe_n, ras_n, we_n, ha_n, pa_n, pra_n, host_ready, hds_n, hoe_n, acc, done;
	logic trqe_n, sf, prb_n;
	logic [31:0] hd;
	int prb_cnt = 0;
	logic [3:0] cas_n, hbs_n = 4'hf;
	logic [26:0] haddr = 27'h0;
	logic [31:0] lad_in, lad_out, rdata, wd = 32'h0, hwd = 32'h0, sh [16];
	logic [32:0] e;
	lmha_req_type req = '0;
	logic [32:0] exp_q [$];
	int error_cnt = 0, comparisons = 0, alt_cnt = 0, cyc = 0, seed = 32'h13373aca;
	always #2 clk = ~clk;
	lmha_ctrl DUT (.CLK_IN(clk), .RST_IN(rst), .LOCAL_ADDR_DATA_BUS_IN(lad_in),
		.LOCAL_ADDR_DATA_BUS_OUT(lad_out), .LOCAL_ADDR_DATA_BUS_OE_N_OUT(oe_n),
		.ADDRESS_LATCH_STROBE_N_OUT(address_latch_strobe_n), .RAS_N_OUT(ras_n), .CAS_N_OUT(cas_n),
		.WE_N_OUT(we_n), .TRANSFER_OUTPUT_ENABLE_N_OUT(trqe_n), .SPECIAL_FUNCTION_PIN_OUT(sf),
		.HALF_WIDTH_ACK_N_IN(ha_n), .PAGE_MODE_ACK_N_IN(pa_n), .BUS_FAULT_IN(fault),
		.BUS_GRANT_N_IN(gnt_n), .PRIORITY_REQUEST_A_N_OUT(pra_n),
		.PRIORITY_REQUEST_B_N_OUT(prb_n),
		.HOST_LONGWORD_ADDR_IN(haddr), .HOST_BYTE_SELECTS_N_IN(hbs_n),
		.HOST_SELECT_N_IN(hsel_n), .HOST_READ_REQ_N_IN(hrd_n), .HOST_WRITE_REQ_N_IN(hwr_n),
		.HOST_INCREMENT_EN_IN(inc), .HOST_PREFETCH_WRITE_EN_IN(pfw), .HOST_READY_OUT(host_ready),
		.HOST_DATA_STROBE_N_OUT(hds_n), .HOST_OUTPUT_ENABLE_N_OUT(hoe_n),
		.CPU_REQ_VALID_IN(valid), .CPU_REQ_IN(req), .CPU_WDATA_IN(wd), .CPU_ACCEPT_OUT(acc),
		.CPU_DONE_OUT(done), .CPU_RDATA_OUT(rdata));
	lmha_mem_model u_mem (.clk_in(clk), .lad_out_in(lad_out), .lad_oe_n_in(oe_n),
		.address_latch_strobe_n_in(address_latch_strobe_n), .cas_n_in(cas_n), .we_n_in(we_n), .hoe_n_in(hoe_n),
		.host_wdata_in(hwd), .half_in(half), .upper_in(upper), .page_in(page),
		.lad_in_out(lad_in), .half_ack_n_out(ha_n), .page_ack_n_out(pa_n));
	// Refresh cycles are the engine's own, so only access cycles are counted
	always @(negedge address_latch_strobe_n) if (!rst && lad_out[3:0] != 4'h3) alt_cnt++;
	// What the host transceivers would latch while the data strobe is low
	always @(posedge clk) if (hds_n === 1'b0 && cas_n === 4'h0) hd <= lad_in;
	always @(posedge clk) if (prb_n === 1'b0) prb_cnt++;
	always @(posedge clk) if (done === 1'b1) begin
		e = exp_q.pop_front();
		if (e[32]) `CHK(rdata, e[31:0])
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			print_verdict();
		end
	end
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic cpu(input logic [3:0] c, input logic [3:0] a, input logic wr,
		input logic chk, input int ea);
		int n, s;
		logic [31:0] d;
		d = $random(seed);
		@(posedge clk);
		req <= {c, 23'h0, a, 4'hf, wr, 2'b00};
		wd <= d;
		valid <= 1;
		exp_q.push_back({chk & !wr, sh[a]});
		if (wr) sh[a] = d;
		n = 0;
		do @(posedge clk); while (acc !== 1'b1 && ++n < 99);
		valid <= 0;
		s = alt_cnt;
		@(negedge address_latch_strobe_n);
		`CHK(lad_out[3:0], (c == 4'hf) ? 4'h8 : c)
		@(negedge ras_n);
		@(posedge clk);
		`CHK(sf, c == 4'h6 || c == 4'h7 || c == 4'he)
		`CHK(trqe_n, !(c == 4'h4 || c == 4'h5))
		`CHK(we_n, !(c == 4'h6 || c == 4'h7))
		do @(posedge clk); while (done !== 1'b1 && ++n < 400);
		`CHK(alt_cnt - s, ea)
	endtask
	task automatic host(input logic rd, input logic [3:0] a, input logic [3:0] bs_n, input int ea);
		int n, s, p;
		logic [31:0] d;
		d = $random(seed);
		@(posedge clk);
		haddr <= {23'h0, a};
		hbs_n <= bs_n;
		hwd <= d;
		hsel_n <= 0;
		if (rd) hrd_n <= 0;
		else hwr_n <= 0;
		s = alt_cnt;
		p = prb_cnt;
		for (int i = 0; i < 4; i++) if (!rd && !bs_n[i]) sh[a][i*8+:8] = d[i*8+:8];
		@(posedge clk);
		// Address and selects move after select falls; only the latched ones may be used
		haddr <= ~haddr;
		hbs_n <= ~bs_n;
		if (!rd) begin
			repeat (2) @(posedge clk);
			hwr_n <= 1;
		end
		if (ea != 0) begin
			@(negedge address_latch_strobe_n);
			`CHK(lad_out[3:0], 4'h2)
		end
		n = 0;
		do @(posedge clk); while (host_ready !== 1'b1 && ++n < 300);
		`CHK(alt_cnt - s, ea)
		`CHK(prb_cnt != p, ea != 0)
		if (rd) `CHK(hd, sh[a])
		repeat (2) @(posedge clk);
		`CHK(rd ? hds_n : hoe_n, 1'b1)
		hsel_n <= 1;
		hrd_n <= 1;
		repeat (40) @(posedge clk); // Leaves room for a background prefetch
	endtask
	initial begin
		for (int i = 0; i < 16; i++) sh[i] = 32'h0000_0000;
		repeat (20) @(posedge clk);
		rst <= 0;
		for (int c = 0; c < 16; c++) cpu(c, c, 0, c >= 8, c != 3);
		$display("test codes done");
		for (int m = 0; m < 6; m++) begin
			{upper, half, page} <= {m >= 4, m >= 2, m[0]};
			cpu(4'h8, m, 1, 0, (m == 2 || m == 4) ? 2 : 1);
			cpu(4'h9, m, 0, 1, (m == 2 || m == 4) ? 2 : 1);
		end
		$display("test sizing done");
		{upper, half, page} <= 3'b010;
		fork
			cpu(4'h8, 4'h3, 0, 1, 3);
			begin
				@(posedge address_latch_strobe_n);
				repeat (4) @(posedge clk);
				fault <= 1;
				@(posedge clk);
				fault <= 0;
			end
		join
		$display("test fault done");
		fork
			cpu(4'ha, 4'h4, 0, 1, 3);
			begin
				@(posedge address_latch_strobe_n);
				gnt_n <= 1;
				repeat (60) @(posedge clk);
				`CHK(pra_n, 1'b0)
				gnt_n <= 0;
			end
		join
		$display("test grant done");
		half <= 0;
		host(0, 4'h6, 4'b1010, 1);
		cpu(4'h8, 4'h6, 0, 1, 1);
		host(1, 4'h6, 4'h0, 1);
		host(1, 4'h7, 4'h0, 1);
		inc <= 1;
		host(1, 4'h8, 4'h0, 1);
		host(1, 4'h9, 4'h0, 0);
		pfw <= 1;
		host(0, 4'ha, 4'b0101, 1);
		host(1, 4'hb, 4'h0, 0);
		cpu(4'hd, 4'ha, 0, 1, 1);
		$display("test host done");
		print_verdict();
	end
endmodule
`default_nettype wire
